// *** bench/dbgpr_host_model.sv ***
`timescale 1ns/100ps
module dbgpr_host_model
  import dbgpr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [31:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic probe_bus_enable_o
);
  initial begin
    reg_addr_o = 8'hFF;
    reg_wdata_o = 32'hFFFFFFFF;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    probe_bus_enable_o = 1'b0;
  end
  // ---------------------------------------------------------------
  // Bus cycles; idle address and data show the inverse of the last
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_wdata_o <= {24'h000000, d};
    reg_wr_o <= 1'b1;
    @(posedge mclk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= {24'hFFFFFF, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge mclk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
  endtask
  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  task automatic set_enable(input logic e);
    @(posedge mclk_i);
    probe_bus_enable_o <= e;
  endtask
  task automatic dig_cmd(input logic [7:0] grp, input logic [7:0] pos);
    wr(REG_GROUP, grp);
    wr(REG_POS, pos);
  endtask
  task automatic ana_cmd(input logic [7:0] sel);
    wr(REG_ANA, sel);
  endtask
endmodule

// *** bench/dbgpr_router_test.sv ***
`timescale 1ns/100ps
module dbgpr_router_test;
  import dbgpr_pkg::*;
  localparam logic [7:0] XMASK [7] = '{8'h00, 8'hFF, 8'h0F, 8'hF0, 8'h33, 8'hCC, 8'h55};
  localparam logic [7:0] GRPS [7] = '{8'h01, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73};
  localparam logic [7:0] VALID [7] = '{8'hFF, 8'h03, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hC7};
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] grp_sig [7] = '{default: 8'h00};
  logic fc_clk = 1'b0;
  logic mfr = 1'b0;
  logic [7:0] len = 8'h00;
  logic [63:0] ana_src = 64'h8877665544332211;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic wr, rd, en;
  logic [3:0] pin, oe;
  logic [7:0] dac1, dac2;
  logic [1:0] dac_en;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 mclk_i = ~mclk_i;
  dbgpr_host_model dbgpr_host_model_i (.mclk_i(mclk_i), .reg_rdata_i(rdata),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
    .probe_bus_enable_o(en));
  dbgpr_router #(.ANA_SRC_NUM(8)) dbgpr_router_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .probe_bus_enable_i(en), .fc_clk_i(fc_clk),
    .clk_sig_i(grp_sig[0]), .txenc_sig_i(grp_sig[1]),
    .timer_sig_i(grp_sig[2]), .card_sig_i(grp_sig[3]),
    .trx_sig_i(grp_sig[4]), .rxdata_sig_i(grp_sig[5]),
    .rxerr_sig_i(grp_sig[6]), .multi_frame_receive_i(mfr), .length_field_i(len),
    .ana_src_i(ana_src), .probe_pin_o(pin), .probe_pin_oe_o(oe), .dac_auxiliary_pin_one_o(dac1),
    .dac_auxiliary_pin_two_o(dac2), .dac_en_o(dac_en));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic drive(input logic [7:0] p);
    @(posedge mclk_i);
    for (int j = 0; j < 7; j++) begin
      grp_sig[j] <= p ^ XMASK[j];
    end
    fc_clk <= p[0];
  endtask
  function automatic logic exp_bit(input int k, input logic [3:0] v);
    logic [7:0] vec;
    vec = grp_sig[k];
    if (k == 6) vec[6] = mfr && (len > 8'h1C);
    if (v == 4'h8) return fc_clk;
    return vec[v[2:0]];
  endfunction
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({oe, pin, dac_en, dac1, dac2}, 0);
    dbgpr_host_model_i.rd(REG_GROUP, rv);
    chk(rv, 0);
    dbgpr_host_model_i.rd(REG_POS, rv);
    chk(rv, 0);
    dbgpr_host_model_i.rd(REG_ANA, rv);
    chk(rv, 0);
    dbgpr_host_model_i.rd(8'h10, rv);
    chk(rv, 0);
    $display("test reset done");
  endtask
  task automatic t_groups();
    int p;
    logic ok;
    for (int k = 0; k < 7; k++) begin
      for (int v = 0; v < 9; v++) begin
        p = (k + v) % 4;
        ok = (v == 8) || VALID[k][v];
        dbgpr_host_model_i.dig_cmd(GRPS[k], 8'((p << 4) | v));
        for (int r = 0; r < 2; r++) begin
          drive(r ? 8'h5A : 8'hA5);
          settle(5);
          chk(oe, ok ? (4'h1 << p) : 4'h0);
          chk(pin, ok ? ({3'h0, exp_bit(k, 4'(v))} << p) : 4'h0);
        end
      end
    end
    $display("test groups done");
  endtask
  task automatic t_rxerr6();
    dbgpr_host_model_i.dig_cmd(8'h73, 8'h16);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i);
      mfr <= (i != 2);
      len <= (i == 0) ? 8'h1C : 8'h1D;
      settle(5);
      chk(pin, {2'h0, i == 1, 1'b0});
    end
    $display("test rx error length done");
  endtask
  task automatic t_pins();
    dbgpr_host_model_i.dig_cmd(8'h01, 8'h34);
    drive(8'h5A);
    settle(5);
    chk(oe, 4'h8);
    chk(pin, {exp_bit(0, 4'h4), 3'h0});
    dbgpr_host_model_i.dig_cmd(8'h1B, 8'h11);
    drive(8'hA5);
    settle(5);
    chk(oe, 4'h2);
    chk(pin, {2'h0, exp_bit(1, 4'h1), 1'b0});
    $display("test pins done");
  endtask
  task automatic t_reserved();
    dbgpr_host_model_i.dig_cmd(8'h02, 8'h00);
    settle(4);
    chk({oe, pin}, 0);
    dbgpr_host_model_i.dig_cmd(8'h01, 8'h40);
    settle(4);
    chk({oe, pin}, 0);
    dbgpr_host_model_i.dig_cmd(8'h30, 8'hF1);
    settle(4);
    chk({oe, pin}, 0);
    dbgpr_host_model_i.dig_cmd(8'h58, 8'h09);
    settle(4);
    chk({oe, pin}, 0);
    $display("test reserved done");
  endtask
  task automatic t_enable_group();
    dbgpr_host_model_i.dig_cmd(8'h30, 8'h30);
    drive(8'h0F);
    settle(5);
    chk({oe, pin}, {4'h8, exp_bit(3, 4'h0), 3'h0});
    dbgpr_host_model_i.wr(REG_GROUP, 8'h1B);
    settle(4);
    chk({oe, pin}, {4'h8, exp_bit(3, 4'h0), 3'h0});
    dbgpr_host_model_i.rd(REG_GROUP, rv);
    chk(rv, 32'h1B);
    dbgpr_host_model_i.set_enable(1'b0);
    settle(5);
    chk({oe, pin}, 0);
    dbgpr_host_model_i.rd(REG_STAT, rv);
    chk(rv, 32'h0);
    dbgpr_host_model_i.set_enable(1'b1);
    settle(5);
    chk({oe, pin}, {4'h8, exp_bit(3, 4'h0), 3'h0});
    dbgpr_host_model_i.rd(REG_STAT, rv);
    chk(rv, 32'h83);
    $display("test enable done");
  endtask
  task automatic t_analog();
    dbgpr_host_model_i.ana_cmd(8'h21);
    settle(2);
    chk({dac_en, dac1, dac2}, {2'b11, 8'h11, 8'h22});
    dbgpr_host_model_i.rd(REG_ANA, rv);
    chk(rv, 32'h21);
    @(posedge mclk_i);
    ana_src <= 64'hF0E1D2C3B4A59687;
    settle(2);
    chk({dac_en, dac1, dac2}, {2'b11, 8'h87, 8'h96});
    dbgpr_host_model_i.ana_cmd(8'h00);
    settle(2);
    chk(dac_en, 2'b00);
    $display("test analog done");
  endtask
  // ---------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    settle(1);
    t_reset();
    dbgpr_host_model_i.set_enable(1'b1);
    t_groups();
    t_rxerr6();
    t_pins();
    t_reserved();
    t_enable_group();
    t_analog();
    conclude();
  end
endmodule

// *** hw/dbgpr_pkg.sv ***
// What this block does
// - The digital probe command has two bytes and the first names the signal group.
// - The low nibble of the second byte picks the signal; 8 picks the 13.56 MHz clock in every valid group.
// - The high nibble of the second byte picks the output pin.
// - Group codes: 01 clock, 1B transmit encoder, 1D timer, 30 card mode, 58 transceive, 70 rx data, 73 rx error.
// - Clock group 0..7: mux 13.56, mux 27.12, RF recovery, PLL, 20 MHz osc, field, PLL lock, clock reset.
// - Timer group 7/5/3 are running flags and 6/4/2 expiry flags of timers zero/one/two; 0 and 1 reserved.
// - Card group 7..0: clock fail, type A, 212 kBd, 424 kBd, type B, end of frame, data, data valid.
// - Transceive group 7..3: prefetch done, prefetch request, tx start, rx enable, wait expired; 2..0 state.
// - Rx data group 7..4 are signal processor collision, end, valid, data; 3 spans the whole reception.
// - Rx data group 2 is actual reception, 1 the receiver chain reset pulse, 0 the decoder bit clock.
// - Rx error group 7,2,1,0 are combined, collision, protocol, integrity; 6 is multi frame with length over 28; 3..5 reserved.
// - Pin nibble in bits 4..7: 0 interrupt pin, 1 general output one, 2 aux pin two, 3 aux pin one; rest reserved.
// - Two converters show up to two internal signals on the two aux pins only.
package dbgpr_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_GROUP = 8'h00;
  localparam logic [7:0] REG_POS = 8'h04;
  localparam logic [7:0] REG_ANA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] GROUP_RST = 8'h00;
  localparam logic [7:0] POS_RST = 8'h00;
  localparam logic [7:0] ANA_RST = 8'h00;
  // ---------------------------------------------------------------
  // Group codes and valid signal masks
  // ---------------------------------------------------------------
  localparam logic [7:0] GRP_CLOCK = 8'h01;
  localparam logic [7:0] GRP_TXENC = 8'h1B;
  localparam logic [7:0] GRP_TIMER = 8'h1D;
  localparam logic [7:0] GRP_CARD = 8'h30;
  localparam logic [7:0] GRP_TRX = 8'h58;
  localparam logic [7:0] GRP_RXDATA = 8'h70;
  localparam logic [7:0] GRP_RXERR = 8'h73;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_TXENC = 8'h03;
  localparam logic [7:0] MASK_TIMER = 8'hFC;
  localparam logic [7:0] MASK_RXERR = 8'hC7;
  // ---------------------------------------------------------------
  // Position byte fields and pins
  // ---------------------------------------------------------------
  localparam int POS_SIG_LSB = 0;
  localparam int POS_PIN_LSB = 4;
  localparam logic [3:0] SIG_FC_CLK = 4'h8;
  localparam logic [3:0] SIG_GROUP_TOP = 4'h7;
  localparam int NUM_PINS = 4;
  localparam logic [3:0] PIN_IRQ = 4'h0;
  localparam logic [3:0] PIN_GENERAL_OUTPUT_ONE = 4'h1;
  localparam logic [3:0] PIN_AUXILIARY_PIN_TWO = 4'h2;
  localparam logic [3:0] PIN_AUXILIARY_PIN_ONE = 4'h3;
  localparam int RXERR_MULTI_BIT = 6;
  localparam logic [7:0] RX_LEN_LIMIT = 8'h1C;
  // ---------------------------------------------------------------
  // Analog byte fields and status bits
  // ---------------------------------------------------------------
  localparam int ANA_ONE_LSB = 0;
  localparam int ANA_TWO_LSB = 4;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_ENABLE_BIT = 1;
  localparam int STAT_OE_LSB = 4;
  localparam int STAT_DAC_LSB = 8;
endpackage

// *** hw/dbgpr_router.sv ***
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module dbgpr_router
  import dbgpr_pkg::*;
#(
  parameter int ANA_SRC_NUM = 8
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic probe_bus_enable_i,
  input wire logic fc_clk_i,
  input wire logic [7:0] clk_sig_i,
  input wire logic [7:0] txenc_sig_i,
  input wire logic [7:0] timer_sig_i,
  input wire logic [7:0] card_sig_i,
  input wire logic [7:0] trx_sig_i,
  input wire logic [7:0] rxdata_sig_i,
  input wire logic [7:0] rxerr_sig_i,
  input wire logic multi_frame_receive_i,
  input wire logic [7:0] length_field_i,
  input wire logic [ANA_SRC_NUM*8-1:0] ana_src_i,
  output logic [NUM_PINS-1:0] probe_pin_o,
  output logic [NUM_PINS-1:0] probe_pin_oe_o,
  output logic [7:0] dac_auxiliary_pin_one_o,
  output logic [7:0] dac_auxiliary_pin_two_o,
  output logic [1:0] dac_en_o
);
  // ---------------------------------------------------------------
  // Synchronised inputs from other clocks and configuration
  // ---------------------------------------------------------------
  logic [7:0] clk_s;
  logic fc_s;
  logic bus_en_s;

  dbgpr_sync #(.WIDTH(10)) u_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({probe_bus_enable_i, fc_clk_i, clk_sig_i}),
    .sync_o({bus_en_s, fc_s, clk_s})
  );

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] stage_group;
  logic [7:0] cfg_group;
  logic [7:0] cfg_pos;
  logic [7:0] cfg_ana;
  logic [31:0] rd_data;
  logic [7:0] next_stage_group;
  logic [7:0] next_cfg_group;
  logic [7:0] next_cfg_pos;
  logic [7:0] next_cfg_ana;
  logic [31:0] next_rd_data;
  logic sel_ok;

  always_comb begin
    next_stage_group = stage_group;
    next_cfg_group = cfg_group;
    next_cfg_pos = cfg_pos;
    next_cfg_ana = cfg_ana;
    next_rd_data = '0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        REG_GROUP: next_stage_group = reg_wdata_i[7:0];
        // Position byte completes the command: group and position apply together
        REG_POS: begin
          next_cfg_group = stage_group;
          next_cfg_pos = reg_wdata_i[7:0];
        end
        REG_ANA: next_cfg_ana = reg_wdata_i[7:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_GROUP: next_rd_data[7:0] = stage_group;
        REG_POS: next_rd_data[7:0] = cfg_pos;
        REG_ANA: next_rd_data[7:0] = cfg_ana;
        REG_STAT: begin
          next_rd_data[STAT_ACTIVE_BIT] = sel_ok;
          next_rd_data[STAT_ENABLE_BIT] = bus_en_s;
          next_rd_data[STAT_OE_LSB +: NUM_PINS] = probe_pin_oe_o;
          next_rd_data[STAT_DAC_LSB +: 2] = dac_en_o;
        end
        default: next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      stage_group <= GROUP_RST;
      cfg_group <= GROUP_RST;
      cfg_pos <= POS_RST;
      cfg_ana <= ANA_RST;
      rd_data <= '0;
    end else begin
      stage_group <= next_stage_group;
      cfg_group <= next_cfg_group;
      cfg_pos <= next_cfg_pos;
      cfg_ana <= next_cfg_ana;
      rd_data <= next_rd_data;
    end
  end

  assign reg_rdata_o = rd_data;

  // ---------------------------------------------------------------
  // Digital probe selection
  // ---------------------------------------------------------------
  logic [3:0] sig_sel;
  logic [3:0] pin_sel;
  logic [7:0] grp_vec;
  logic [7:0] grp_mask;
  logic grp_ok;
  logic sig_ok;
  logic sel_val;
  logic len_over;

  assign sig_sel = cfg_pos[POS_SIG_LSB +: 4];
  assign pin_sel = cfg_pos[POS_PIN_LSB +: 4];
  assign len_over = multi_frame_receive_i && (length_field_i > RX_LEN_LIMIT);

  always_comb begin
    grp_vec = '0;
    grp_mask = '0;
    grp_ok = 1'b1;
    case (cfg_group)
      GRP_CLOCK: begin
        grp_vec = clk_s;
        grp_mask = MASK_FULL;
      end
      GRP_TXENC: begin
        grp_vec = txenc_sig_i;
        grp_mask = MASK_TXENC;
      end
      GRP_TIMER: begin
        grp_vec = timer_sig_i;
        grp_mask = MASK_TIMER;
      end
      GRP_CARD: begin
        grp_vec = card_sig_i;
        grp_mask = MASK_FULL;
      end
      GRP_TRX: begin
        grp_vec = trx_sig_i;
        grp_mask = MASK_FULL;
      end
      GRP_RXDATA: begin
        grp_vec = rxdata_sig_i;
        grp_mask = MASK_FULL;
      end
      GRP_RXERR: begin
        grp_vec = rxerr_sig_i;
        grp_vec[RXERR_MULTI_BIT] = len_over;
        grp_mask = MASK_RXERR;
      end
      default: grp_ok = 1'b0;
    endcase
  end

  always_comb begin
    sig_ok = 1'b0;
    sel_val = 1'b0;
    if (sig_sel == SIG_FC_CLK) begin
      sig_ok = 1'b1;
      sel_val = fc_s;
    end else if (sig_sel <= SIG_GROUP_TOP) begin
      sig_ok = grp_mask[sig_sel[2:0]];
      sel_val = grp_vec[sig_sel[2:0]];
    end
  end

  // Probe bus enable gates every route; reserved codes stay inactive
  assign sel_ok = bus_en_s && grp_ok && sig_ok && (pin_sel < 4'(NUM_PINS));

  logic [NUM_PINS-1:0] next_pin;
  logic [NUM_PINS-1:0] next_oe;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      always_comb begin
        next_oe[gp] = sel_ok && (pin_sel == 4'(gp));
        next_pin[gp] = next_oe[gp] && sel_val;
      end

      always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
          probe_pin_o[gp] <= 1'b0;
          probe_pin_oe_o[gp] <= 1'b0;
        end else begin
          probe_pin_o[gp] <= next_pin[gp];
          probe_pin_oe_o[gp] <= next_oe[gp];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Analog probe converters, aux pins only
  // ---------------------------------------------------------------
  logic [3:0] ana_one_sel;
  logic [3:0] ana_two_sel;
  logic [7:0] next_dac1;
  logic [7:0] next_dac2;
  logic [1:0] next_dac_en;

  assign ana_one_sel = cfg_ana[ANA_ONE_LSB +: 4];
  assign ana_two_sel = cfg_ana[ANA_TWO_LSB +: 4];

  // Source 0 switches a converter off; sources 1..ANA_SRC_NUM pick a word
  always_comb begin
    next_dac1 = '0;
    next_dac2 = '0;
    next_dac_en = '0;
    for (int i = 0; i < ANA_SRC_NUM; i++) begin
      if (bus_en_s && ana_one_sel == 4'(i + 1)) begin
        next_dac1 = ana_src_i[i*8 +: 8];
        next_dac_en[0] = 1'b1;
      end
      if (bus_en_s && ana_two_sel == 4'(i + 1)) begin
        next_dac2 = ana_src_i[i*8 +: 8];
        next_dac_en[1] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dac_auxiliary_pin_one_o <= '0;
      dac_auxiliary_pin_two_o <= '0;
      dac_en_o <= '0;
    end else begin
      dac_auxiliary_pin_one_o <= next_dac1;
      dac_auxiliary_pin_two_o <= next_dac2;
      dac_en_o <= next_dac_en;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  bus_gate_a: assert property (
    !bus_en_s |=> (probe_pin_oe_o == '0) && (dac_en_o == '0))
    else $error("probe output active while probe bus disabled");

  cmd_commit_a: assert property (
    (reg_wr_i && reg_addr_i == REG_POS) |=> (cfg_group == $past(stage_group)) ##1
      (probe_pin_oe_o == '0 || cfg_group == $past(cfg_group)))
    else $error("position write did not commit the staged group");

  fc_route_a: assert property (
    (bus_en_s && grp_ok && sig_sel == SIG_FC_CLK && pin_sel == PIN_IRQ)
      |=> probe_pin_oe_o[0] && (probe_pin_o[0] == $past(fc_s)))
    else $error("13.56 MHz clock not routed");

  pin_auxiliary_pin_two_a: assert property (
    (sel_ok && pin_sel == PIN_AUXILIARY_PIN_TWO) |=> (probe_pin_oe_o == 4'h4))
    else $error("aux pin two not the only driven pin");

  clk_osc_a: assert property (
    (bus_en_s && cfg_group == GRP_CLOCK && sig_sel == 4'h4 && pin_sel == PIN_AUXILIARY_PIN_ONE)
      |=> probe_pin_o[3] == $past(clk_s[4]))
    else $error("oscillator clock not on aux pin one");

  timer_rsvd_a: assert property (
    (cfg_group == GRP_TIMER && sig_sel < 4'h2) |=> probe_pin_oe_o == '0)
    else $error("reserved timer value drives a pin");

  txenc_env_a: assert property (
    (bus_en_s && cfg_group == GRP_TXENC && sig_sel == 4'h1 && pin_sel == PIN_GENERAL_OUTPUT_ONE)
      |=> probe_pin_o[1] == $past(txenc_sig_i[1]))
    else $error("transmit envelope not routed");

  rxerr_len_a: assert property (
    (bus_en_s && cfg_group == GRP_RXERR && sig_sel == 4'h6 && pin_sel == PIN_GENERAL_OUTPUT_ONE)
      |=> probe_pin_o[1] == ($past(multi_frame_receive_i) && $past(length_field_i) > 8'h1C))
    else $error("multi frame length flag wrong");

  rsvd_pin_a: assert property (
    (pin_sel >= 4'(NUM_PINS) || !grp_ok) |=> probe_pin_oe_o == '0)
    else $error("reserved pin or group drives a pin");

  stat_read_a: assert property (
    (reg_rd_i && reg_addr_i == REG_STAT) |=> reg_rdata_o[STAT_ENABLE_BIT] == $past(bus_en_s))
    else $error("status read wrong");

  fc_route_c: cover property (sel_ok && sig_sel == SIG_FC_CLK ##1 probe_pin_o != '0);
  rxdata_route_c: cover property (sel_ok && cfg_group == GRP_RXDATA ##1 probe_pin_oe_o[3]);
  dac_both_c: cover property (dac_en_o == 2'h3);
endmodule

// *** hw/dbgpr_sync.sv ***
`timescale 1ns/100ps
module dbgpr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule
